// >>> hwtc_defines.svh
// Register offsets, reset values and timing figures of the host timer block
`ifndef HWTC_DEFINES_SVH
`define HWTC_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the host bus
// ****************************************************************
`define HWTC_OFS_TIMER_CFG    8'h8C
`define HWTC_OFS_TIMER_CNT    8'h90
`define HWTC_OFS_HALF_ORDER   8'h98
`define HWTC_OFS_FREE_TICK    8'h9C
`define HWTC_OFS_DROP_TALLY   8'hA0

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define HWTC_TIMER_EN_BIT     5'd29
`define HWTC_TIMER_EN_HBIT    4'd13
`define HWTC_PRELOAD_RST      16'hFFFF
`define HWTC_COUNT_RST        16'hFFFF
`define HWTC_HALF_ORDER_RST   32'h0000_0000
`define HWTC_HALF_SWAP_VAL    32'hFFFF_FFFF
`define HWTC_DROP_RST         32'h0000_0000
`define HWTC_DROP_BELOW_HALF  32'h7FFF_FFFF
`define HWTC_HALF_ZERO        16'h0000
`define HWTC_TIMER_ZERO       16'h0000
`define HWTC_TIMER_ONE        16'h0001

// ****************************************************************
// Timing: core clock, timer tick, free counter rate
// ****************************************************************
`define HWTC_CLK_PERIOD_NS    50
`define HWTC_TICK_NS          100000
`define HWTC_TICK_CYCLES      ((`HWTC_TICK_NS) / (`HWTC_CLK_PERIOD_NS))
`define HWTC_TICK_W           12
`define HWTC_FREE_PHASE_LAST  2'h3
`define HWTC_STEP_ONE         2'h1
`define HWTC_STEP_TWO         2'h2
`define HWTC_STEP_NONE        2'h0

// ****************************************************************
// Control pin positions in the synchronised strobe vector
// ****************************************************************
`define HWTC_PIN_CS           0
`define HWTC_PIN_RD           1
`define HWTC_PIN_WR           2
`define HWTC_PINS_IDLE        3'h7

`endif

// >>> hwtc_pkg.sv
// Types shared by the host timer and counter block
package hwtc_pkg;

  // Host access taken from the synchronised bus pins
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:1]  addr;
    logic [15:0] wdata;
  } hwtc_req_t;

  // Event pulses handed to the interrupt controller
  typedef struct packed {
    logic timer_expired;
    logic drop_half;
  } hwtc_evt_t;

endpackage

// >>> hwtc_count32.sv
// 32-bit wrapping counter with synchronous clear, step and read pairing
`timescale 1ns/1ps
`include "hwtc_defines.svh"

module hwtc_count32
  import hwtc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic [1:0]  step,
  input  wire logic        rd,
  input  wire logic        half_hi,
  output logic      [31:0] value,
  output logic      [31:0] rd_word,
  output logic             first
);

  logic [31:0] value_q;
  logic [31:0] value_d;
  logic [31:0] snap_q;
  logic        armed_q;
  logic        seen_hi_q;

  // A read of either half starts a pair unless it completes one
  assign first = !armed_q || (half_hi == seen_hi_q);

  // A step in the clear cycle is kept: the clear only drops the old total
  always_comb
  begin
    value_d = (clr ? `HWTC_DROP_RST : value_q) + {30'h0, step};
  end

  // Natural wrap at the top of the 32-bit range
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      value_q <= `HWTC_DROP_RST;
    else
      value_q <= value_d;
  end

  // Snapshot so both halves of a pair come from one instant
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      snap_q    <= `HWTC_DROP_RST;
      armed_q   <= 1'b0;
      seen_hi_q <= 1'b0;
    end
    else if (rd)
    begin
      if (first)
      begin
        snap_q    <= value_q; // [RULE10]
        armed_q   <= 1'b1;
        seen_hi_q <= half_hi;
      end
      else
        armed_q   <= 1'b0;
    end
  end

  // The opening read sees the live count, the closing one the snapshot
  assign value   = value_q;
  assign rd_word = first ? value_q : snap_q;

endmodule // hwtc_count32

// >>> hwtc_top.sv
// Host timer, halfword order, free tick and dropped frame counters
`timescale 1ns/1ps
`include "hwtc_defines.svh"

// Summary of operation
// (RULE1) Run bit starts timer; clearing halts it
// (RULE2) Run bit falling forces preload to FFFFh
// (RULE3) Preload field bits 15-0, resets FFFFh
// (RULE4) Timer raises interrupt at preload-defined intervals
// (RULE5) Read-only count field shows timer, resets FFFFh
// (RULE6) All-ones order: A1=1 low half
// (RULE7) Otherwise A1=1 selects the high half
// (RULE8) FIFO halves always low-first to network
// (RULE9) Free counter: 32 bits, 25MHz, wraps
// (RULE10) First read snapshots the whole free count
// (RULE11) Host waits 160ns for counter clear
// (RULE12) Free counter runs in every power state
// (RULE13) Dropped counter increments per discarded frame
// (RULE14) Reading dropped counter clears it
// (RULE15) Event when dropped counter reaches 80000000h
// (RULE16) Timer counts down, flags zero, reloads

module hwtc_top
  import hwtc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        host_cs_n,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n,
  input  wire logic [7:1]  host_addr,
  input  wire logic [15:0] host_data_in,
  output logic      [15:0] host_data_out,
  output logic             host_data_oe,
  output logic             host_half_hi,
  input  wire logic        frame_dropped,
  output hwtc_evt_t        events
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0]  pin_s1_q;
  logic [2:0]  pin_s2_q;
  logic [2:0]  pin_s3_q;
  logic [2:0]  pin_q;
  logic [2:0]  pin_old_q;
  logic [22:0] bus_s1_q;
  logic [22:0] bus_s2_q;
  logic [22:0] bus_s3_q;

  // Three stages; the first is read only by the second
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= `HWTC_PINS_IDLE;
      pin_s2_q <= `HWTC_PINS_IDLE;
      pin_s3_q <= `HWTC_PINS_IDLE;
      bus_s1_q <= 23'h0;
      bus_s2_q <= 23'h0;
      bus_s3_q <= 23'h0;
    end
    else
    begin
      pin_s1_q <= {host_wr_n, host_rd_n, host_cs_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      bus_s1_q <= {host_addr, host_data_in};
      bus_s2_q <= bus_s1_q;
      bus_s3_q <= bus_s2_q;
    end
  end

  // A strobe level counts only once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_q     <= `HWTC_PINS_IDLE;
      pin_old_q <= `HWTC_PINS_IDLE;
    end
    else
    begin
      pin_q     <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q))
                 | (pin_q & (pin_s2_q ^ pin_s3_q));
      pin_old_q <= pin_q;
    end
  end

  // ****************************************************************
  // Access decode
  // ****************************************************************
  hwtc_req_t   req;
  logic [7:0]  req_ofs;
  logic        swap_active;
  logic        half_hi;
  logic [31:0] half_order_q;

  // One access per falling strobe while the chip select is low
  always_comb
  begin
    req.rd    = !pin_q[`HWTC_PIN_RD] && pin_old_q[`HWTC_PIN_RD]
                && !pin_q[`HWTC_PIN_CS];
    req.wr    = !pin_q[`HWTC_PIN_WR] && pin_old_q[`HWTC_PIN_WR]
                && !pin_q[`HWTC_PIN_CS];
    req.addr  = bus_s3_q[22:16];
    req.wdata = bus_s3_q[15:0];
    req_ofs   = {req.addr[7:2], 2'b00};
  end

  // Only the exact all-ones pattern swaps; anything else is straight
  assign swap_active = (half_order_q == `HWTC_HALF_SWAP_VAL); // [RULE6]
  assign half_hi     = req.addr[1] ^ swap_active;             // [RULE7]

  // FIFO paths use this half select for host words only; their network
  // side stays low-half-first whatever the order register holds
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      host_half_hi <= 1'b0;
    else
      host_half_hi <= half_hi; // [RULE8]
  end

  // ****************************************************************
  // Halfword order register
  // ****************************************************************
  // Written one half at a time, each half placed by the resolved select
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      half_order_q <= `HWTC_HALF_ORDER_RST;
    else if (req.wr && req_ofs == `HWTC_OFS_HALF_ORDER)
    begin
      if (half_hi)
        half_order_q[31:16] <= req.wdata;
      else
        half_order_q[15:0]  <= req.wdata;
    end
  end

  // ****************************************************************
  // General purpose timer
  // ****************************************************************
  logic                    timer_en_q;
  logic [15:0]             preload_q;
  logic [15:0]             timer_cnt_q;
  logic [`HWTC_TICK_W-1:0] tick_div_q;
  logic                    tick;
  logic                    cfg_hi_wr;
  logic                    cfg_lo_wr;
  logic                    new_en;

  assign cfg_hi_wr = req.wr && req_ofs == `HWTC_OFS_TIMER_CFG && half_hi;
  assign cfg_lo_wr = req.wr && req_ofs == `HWTC_OFS_TIMER_CFG && !half_hi;
  assign new_en    = req.wdata[`HWTC_TIMER_EN_HBIT];

  // Run bit held in the upper half of the configuration word
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      timer_en_q <= 1'b0;
    else if (cfg_hi_wr)
      timer_en_q <= new_en; // [RULE1]
  end

  // Preload; a halt forces it back to all ones
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      preload_q <= `HWTC_PRELOAD_RST; // [RULE3]
    else if (cfg_hi_wr && timer_en_q && !new_en)
      preload_q <= `HWTC_PRELOAD_RST; // [RULE2]
    else if (cfg_lo_wr)
      preload_q <= req.wdata; // [RULE3]
  end

  // Tick divider; kept coarse so a 16-bit preload spans useful times
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !timer_en_q)
      tick_div_q <= '0;
    else if (tick)
      tick_div_q <= '0;
    else
      tick_div_q <= tick_div_q + `HWTC_TICK_W'(1);
  end

  assign tick = (tick_div_q == `HWTC_TICK_W'(`HWTC_TICK_CYCLES - 1));

  // Count down while running, reload after zero; halted count holds
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      timer_cnt_q <= `HWTC_COUNT_RST; // [RULE5]
    else if (cfg_hi_wr && !timer_en_q && new_en)
      timer_cnt_q <= preload_q; // [RULE1]
    else if (timer_en_q && tick)
    begin
      if (timer_cnt_q == `HWTC_TIMER_ZERO)
        timer_cnt_q <= preload_q; // [RULE16]
      else
        timer_cnt_q <= timer_cnt_q - `HWTC_TIMER_ONE; // [RULE16]
    end
  end

  // One-cycle event each time the count expires
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      events.timer_expired <= 1'b0;
    else
      events.timer_expired <= timer_en_q && tick
                              && timer_cnt_q == `HWTC_TIMER_ZERO; // [RULE4]
  end

  // ****************************************************************
  // Free tick counter
  // ****************************************************************
  logic [1:0]  free_phase_q;
  logic [1:0]  free_step;
  logic [31:0] free_word;
  logic        free_rd;

  // 25 MHz average from 20 MHz: five steps every four core cycles
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      free_phase_q <= 2'h0;
    else
      free_phase_q <= free_phase_q + 2'h1;
  end

  assign free_step = (free_phase_q == `HWTC_FREE_PHASE_LAST) ?
                     `HWTC_STEP_TWO : `HWTC_STEP_ONE; // [RULE9]

  assign free_rd = req.rd && req_ofs == `HWTC_OFS_FREE_TICK;

  // No power state input gates this counter, so it runs in all of them
  hwtc_count32 u_free_cnt
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (1'b0),
    .step     (free_step), // [RULE12]
    .rd       (free_rd),
    .half_hi  (half_hi),
    .value    (),          // [RULE9]
    .rd_word  (free_word), // [RULE10]
    .first    ()
  );

  // ****************************************************************
  // Dropped frame counter
  // ****************************************************************
  logic [31:0] drop_live;
  logic [31:0] drop_word;
  logic        drop_rd;
  logic        drop_first;
  logic        drop_clr;
  assign drop_rd  = req.rd && req_ofs == `HWTC_OFS_DROP_TALLY;
  assign drop_clr = drop_rd && drop_first; // [RULE14]

  // A frame dropped in the clearing cycle is kept as a count of one; the
  // clearing read also snapshots, so the other half is not lost
  hwtc_count32 u_drop_cnt
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (drop_clr), // [RULE14]
    .step     (frame_dropped ? `HWTC_STEP_ONE
                             : `HWTC_STEP_NONE), // [RULE13]
    .rd       (drop_rd),
    .half_hi  (half_hi),
    .value    (drop_live),
    .rd_word  (drop_word),
    .first    (drop_first)
  );

  // Midpoint event when the count steps from 7FFFFFFFh upward
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      events.drop_half <= 1'b0;
    else
      events.drop_half <= frame_dropped && !drop_clr
                          && drop_live == `HWTC_DROP_BELOW_HALF; // [RULE15]
  end

  // ****************************************************************
  // Read data path
  // ****************************************************************
  logic [31:0] rd_word;
  logic [15:0] rdata_d;

  // Reserved bits read as zero; unmapped offsets read as zero
  always_comb
  begin
    rd_word = 32'h0;
    unique case (req_ofs)
      `HWTC_OFS_TIMER_CFG:
      begin
        rd_word[15:0]               = preload_q;
        rd_word[`HWTC_TIMER_EN_BIT] = timer_en_q;
      end
      `HWTC_OFS_TIMER_CNT:  rd_word[15:0] = timer_cnt_q; // [RULE5]
      `HWTC_OFS_HALF_ORDER: rd_word = half_order_q;
      `HWTC_OFS_FREE_TICK:  rd_word = free_word; // [RULE10]
      `HWTC_OFS_DROP_TALLY: rd_word = drop_word; // [RULE14]
      default: rd_word = 32'h0;
    endcase
    rdata_d = half_hi ? rd_word[31:16] : rd_word[15:0]; // [RULE6]
  end

  // Data is captured once per read strobe and held until the next
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      host_data_out <= `HWTC_HALF_ZERO;
    else if (req.rd)
      host_data_out <= rdata_d;
  end

  // Drive only while the synchronised read and select are both low
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      host_data_oe <= 1'b0;
    else
      host_data_oe <= !pin_q[`HWTC_PIN_RD] && !pin_q[`HWTC_PIN_CS];
  end

endmodule // hwtc_top

// >>> hwtc_top_chk.sv
// Port-level assertions for the host timer and counter block
`timescale 1ns/1ps

module hwtc_top_chk
  import hwtc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        host_cs_n,
  input wire logic        host_rd_n,
  input wire logic        host_wr_n,
  input wire logic [7:1]  host_addr,
  input wire logic [15:0] host_data_in,
  input wire logic [15:0] host_data_out,
  input wire logic        host_data_oe,
  input wire logic        host_half_hi,
  input wire logic        frame_dropped,
  input wire hwtc_evt_t   events
);
  // ****************************************************************
  // Bus and event checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking

  // Reset quiets the outputs; no disable, reset is the cause here
  AST_RST_QUIET: assert property (
    !rst_n |=> !host_data_oe && events == 2'h0)
    else $error("Outputs not quiet after reset");
  AST_RST_DATA: assert property (
    !rst_n |=> host_data_out == 16'h0000)
    else $error("Read data not cleared by reset");
  // A read strobe held for eight cycles has the data pins driven by its last cycle
  AST_RD_ANSWER: assert property (disable iff (!rst_n)
    ($fell(host_rd_n) && !host_cs_n) ##1 (!host_rd_n && !host_cs_n)[*7]
    |-> host_data_oe) else $error("Read strobe got no answer");
  AST_OE_CAUSE: assert property (disable iff (!rst_n)
    $rose(host_data_oe) |-> $past(host_rd_n, 2) == 1'b0)
    else $error("Data driven without a read strobe");
  // Writes and idle bus must never turn the data pins around
  AST_OE_IDLE: assert property (disable iff (!rst_n)
    host_rd_n[*8] |-> !host_data_oe)
    else $error("Data driven while read strobe idle");
  AST_DATA_HOLD: assert property (disable iff (!rst_n)
    host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
    else $error("Read data changed during a read");
  AST_TIMER_GAP: assert property (disable iff (!rst_n)
    events.timer_expired |=> (!events.timer_expired)[*8])
    else $error("Timer events too close together");
  AST_DROP_PULSE: assert property (disable iff (!rst_n)
    events.drop_half |=> !events.drop_half)
    else $error("Midpoint event longer than one cycle");
  AST_DROP_CAUSE: assert property (disable iff (!rst_n)
    events.drop_half |-> $past(frame_dropped) || $past(frame_dropped, 2))
    else $error("Midpoint event without a dropped frame");

  // Main scenarios reached
  COV_TIMER: cover property (events.timer_expired);
  COV_READ: cover property ($rose(host_data_oe));
  COV_DROP: cover property (frame_dropped);
endmodule // hwtc_top_chk

// >>> hwtc_host_model.sv
// Behavioural host CPU on the SRAM-like register bus
`timescale 1ns/1ps

module hwtc_host_model
(
  input  wire logic        core_clk,
  output logic             host_cs_n,
  output logic             host_rd_n,
  output logic             host_wr_n,
  output logic      [7:1]  host_addr,
  output logic      [15:0] host_data_in,
  input  wire logic [15:0] host_data_out,
  input  wire logic        host_half_hi
);
  // ****************************************************************
  // Bus cycle
  // ****************************************************************
  initial
  begin
    host_cs_n    = 1'b1;
    host_rd_n    = 1'b1;
    host_wr_n    = 1'b1;
    host_addr    = 7'h00;
    host_data_in = 16'h0000;
  end

  // Strobe held 8 cycles so the 3-stage sync sees it; 5 idle cycles after
  task automatic access(input logic [7:0] ofs, input logic wr_en,
                        input logic [15:0] wd, output logic [15:0] rdat,
                        output logic half);
    @(posedge core_clk);
    #2;
    host_addr    = ofs[7:1];
    host_cs_n    = 1'b0;
    host_data_in = wd;
    if (wr_en)
      host_wr_n = 1'b0;
    else
      host_rd_n = 1'b0;
    repeat (8) @(posedge core_clk);
    rdat = host_data_out;
    half = host_half_hi;
    #2;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    // Released data pins do not keep their last value
    host_data_in = ~host_data_in;
    repeat (5) @(posedge core_clk);
  endtask
endmodule // hwtc_host_model

// >>> tb_top.sv
// Self-checking testbench for the host timer and counter block
`timescale 1ns/1ps

module tb_top;
  import hwtc_pkg::*;
  logic        core_clk, rst_n, host_cs_n, host_rd_n, host_wr_n;
  logic [7:1]  host_addr;
  logic [15:0] host_data_in, host_data_out, c0, c1, f0, f1, fh;
  logic        host_data_oe, host_half_hi, frame_dropped, swapped, h;
  hwtc_evt_t   events;
  int          error_cnt, tests_run, n;

  // ****************************************************************
  // Instances and helpers
  // ****************************************************************
  hwtc_top dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .host_half_hi(host_half_hi), .frame_dropped(frame_dropped),
    .events(events));
  hwtc_host_model host_u (.core_clk(core_clk), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_half_hi(host_half_hi));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Half select follows A1, inverted when the swap word is all ones
  task automatic rd(logic [7:0] ofs, logic [15:0] exp, string name);
    logic [15:0] d;
    logic        hh;
    host_u.access(ofs, 1'b0, 16'h0000, d, hh);
    check(name, {16'h0000, d}, {16'h0000, exp});
    check("half_sel", {31'h0, hh}, {31'h0, ofs[1] ^ swapped});
  endtask

  task automatic wr(logic [7:0] ofs, logic [15:0] wd);
    logic [15:0] d;
    logic        hh;
    host_u.access(ofs, 1'b1, wd, d, hh);
  endtask

  // Cycles to the next timer event, or lim if none came
  task automatic wait_evt(int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      cnt++;
    end while (cnt < lim && events.timer_expired !== 1'b1);
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Whole run needs about 18000 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    rst_n = 1'b0;
    frame_dropped = 1'b0;
    swapped = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    repeat (4) @(posedge core_clk); // Beyond counter clear time
    rd(8'h8C, 16'hFFFF, "cfg_lo");
    rd(8'h8E, 16'h0000, "cfg_hi");
    rd(8'h84, 16'h0000, "unmapped");
    wr(8'h90, 16'h1234);
    rd(8'h90, 16'hFFFF, "cnt_lo");
    rd(8'h98, 16'h0000, "order_lo");
    rd(8'h9A, 16'h0000, "order_hi");
    // Free counter: 428 cycles at 20 MHz are exactly 535 counts
    host_u.access(8'h9C, 1'b0, 16'h0000, f0, h);
    host_u.access(8'h9E, 1'b0, 16'h0000, fh, h);
    check("free_hi", fh, 16'h0000);
    repeat (400) @(posedge core_clk);
    host_u.access(8'h9C, 1'b0, 16'h0000, f1, h);
    host_u.access(8'h9E, 1'b0, 16'h0000, fh, h);
    check("free_step", f1 - f0, 16'h0217);
    // Five dropped frames, then clear on read
    repeat (5)
    begin
      @(posedge core_clk);
      #2 frame_dropped = 1'b1;
      @(posedge core_clk);
      #2 frame_dropped = 1'b0;
    end
    rd(8'hA0, 16'h0005, "drop_lo");
    rd(8'hA2, 16'h0000, "drop_hi");
    rd(8'hA0, 16'h0000, "drop_clr");
    // Timer: preload 2 gives 3 ticks of 2000 cycles
    wr(8'h8C, 16'h0002);
    wr(8'h8E, 16'h2000);
    wait_evt(8000, n);
    check("timer_fire", n < 8000, 1);
    wait_evt(8000, n);
    check("period", n, 6000);
    wr(8'h8E, 16'h0000);
    rd(8'h8C, 16'hFFFF, "preload_forced");
    host_u.access(8'h90, 1'b0, 16'h0000, c0, h);
    wait_evt(5000, n);
    check("halted_evt", n, 5000);
    host_u.access(8'h90, 1'b0, 16'h0000, c1, h);
    check("halted_cnt", c1, c0);
    // Swap word all ones flips the half select
    wr(8'h9A, 16'hFFFF);
    wr(8'h98, 16'hFFFF);
    swapped = 1'b1;
    rd(8'h8C, 16'h0000, "swap_cfg_hi");
    rd(8'h8E, 16'hFFFF, "swap_cfg_lo");
    wr(8'h98, 16'h1234);
    swapped = 1'b0;
    rd(8'h98, 16'hFFFF, "order_lo2");
    rd(8'h9A, 16'h1234, "order_hi2");
    wrap_up();
  end
endmodule // tb_top

bind hwtc_top hwtc_top_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
  .host_addr(host_addr), .host_data_in(host_data_in),
  .host_data_out(host_data_out), .host_data_oe(host_data_oe),
  .host_half_hi(host_half_hi), .frame_dropped(frame_dropped),
  .events(events));
